// file: verif/ucp_pins_chk.sv
/*
  Checker on the parallel pins joining the host end and the device end.
  Assumes one aclk domain and instantiation beside the interface.
*/
`timescale 1ns/10ps
module ucp_pins_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic width_select_low,
  input wire logic width_select_high,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_lane0_n,
  input wire logic write_strobe_lane1_n,
  input wire logic write_strobe_lane2_n,
  input wire logic write_strobe_lane3_n,
  input wire logic [10:2] upper_address,
  input wire logic hw_reset_n,
  input wire logic [3:0] dev_data_oe_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [4:0] low_q;
  logic [4:0] low_d;
  // Saturates so a stuck reset pin cannot wrap and look short
  always_comb begin
    low_d = hw_reset_n ? 5'h00 : ((low_q == 5'h1f) ? low_q : low_q + 5'h01);
  end
  always_ff @(posedge aclk) begin
    low_q <= aresetn ? low_d : 5'h00;
  end
  a_rst_pulse_len: assert property ($rose(hw_reset_n) |-> low_q >= 5'h0a) else $error("reset pulse short");
  a_read_drive: assert property (!chip_select_n && !read_strobe_n |=>
    dev_data_oe_n == (width_select_high ? 4'h0 : (width_select_low ? 4'hc : 4'he))) else $error("read lanes wrong");
  a_bus_release: assert property ((chip_select_n || read_strobe_n) |=> dev_data_oe_n == 4'hf)
    else $error("data driven while idle");
  a_narrow_upper: assert property (!width_select_high |-> dev_data_oe_n[3:2] == 2'b11)
    else $error("upper lanes driven");
  a_strobe_with_cs: assert property (!read_strobe_n || (width_select_high && !write_strobe_lane3_n)
    |-> !chip_select_n) else $error("strobe without select");
  a_strobe_len: assert property ($fell(read_strobe_n) |-> !read_strobe_n [*3] ##1 read_strobe_n)
    else $error("read strobe length");
  a_addr_stable: assert property (!chip_select_n && !$past(chip_select_n) |-> $stable(upper_address))
    else $error("address moved in access");
  a_endian_steady: assert property (!width_select_high && !chip_select_n && !$past(chip_select_n)
    |-> $stable(write_strobe_lane3_n)) else $error("endian level moved");
  a_addr_pins_8b: assert property (!width_select_high && !width_select_low && !chip_select_n
    && !$past(chip_select_n) |-> $stable(write_strobe_lane1_n) && $stable(write_strobe_lane2_n))
    else $error("narrow address pins moved");
  c_read32: cover property (width_select_high && !chip_select_n && !read_strobe_n);
  c_write8: cover property (!width_select_high && !width_select_low && !write_strobe_lane0_n);
  c_hw_reset: cover property ($rose(hw_reset_n));
endmodule

// file: verif/user_cpu_bus_port_bench.sv
/*
  Bench: host end and device end joined by the pin interface; AXI4-Lite
  orders to the host, device event inputs driven directly.
  Assumes the defs header on the include path.
*/
`timescale 1ns/10ps
`include "ucp_defs.svh"
module user_cpu_bus_port_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, irq_trigger = 8'h00, irq_enable = 8'h00, irq_clear = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, endian_big, write_seen;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] irq_status;
  logic [7:0] flt_q = 8'h00;
  int err_count = 0;
  int checks = 0;
  int low_cnt = 0;
  int seen_cnt = 0;
  ucp_if bus();
  ucp_host u_ucp_host (.aclk(aclk), .aresetn(aresetn), .bus(bus), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
  ucp_device u_ucp_device (.aclk(aclk), .aresetn(aresetn), .bus(bus), .irq_trigger(irq_trigger),
    .irq_enable(irq_enable), .irq_clear(irq_clear), .irq_status(irq_status), .endian_big(endian_big),
    .write_seen(write_seen));
  ucp_pins_chk u_ucp_pins_chk (.aclk(aclk), .aresetn(aresetn), .width_select_low(bus.width_select_low),
    .width_select_high(bus.width_select_high), .chip_select_n(bus.chip_select_n),
    .read_strobe_n(bus.read_strobe_n), .write_strobe_lane0_n(bus.write_strobe_lane0_n),
    .write_strobe_lane1_n(bus.write_strobe_lane1_n), .write_strobe_lane2_n(bus.write_strobe_lane2_n),
    .write_strobe_lane3_n(bus.write_strobe_lane3_n), .upper_address(bus.upper_address),
    .hw_reset_n(bus.hw_reset_n), .dev_data_oe_n(bus.dev_data_oe_n));
  initial begin
    forever #4 aclk = ~aclk;
  end
  // Undriven lanes show a moving pattern so stale data cannot pass
  always @(posedge aclk) flt_q <= flt_q + 8'h3b;
  always @(posedge aclk) if (bus.hw_reset_n === 1'b0) low_cnt++;
  always @(posedge aclk) if (write_seen === 1'b1) seen_cnt++;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bus.data_in[i*8 +: 8] = !bus.host_data_oe_n[i] ? bus.host_data_out[i*8 +: 8] :
        (!bus.dev_data_oe_n[i] ? bus.dev_data_out[i*8 +: 8] : flt_q);
    end
  end
  task automatic print_verdict();
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic timeout();
    err_count++;
    print_verdict();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    chk({30'h0, bresp}, 32'h0);
    bready <= 1'b0;
    if (n == 50) timeout();
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 50) timeout();
  endtask
  task automatic par_op(input logic [10:0] ad, input logic [31:0] d, input logic [7:0] ctrl);
    logic [31:0] s;
    logic [1:0] r;
    int n;
    axi_wr(`UCP_CSR_ADDR, {21'h0, ad});
    axi_wr(`UCP_CSR_WDATA, d);
    axi_wr(`UCP_CSR_CTRL, {24'h0, ctrl});
    for (n = 0; n < 40; n++) begin
      axi_rd(`UCP_CSR_STAT, s, r);
      if (s[0] === 1'b0) break;
    end
    if (n == 40) timeout();
  endtask
  task automatic rd_port(input logic [10:0] ad, input logic [31:0] msk, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    par_op(ad, 32'h0, 8'h01);
    axi_rd(`UCP_CSR_RDATA, d, r);
    chk(d & msk, exp);
  endtask
  task automatic t_reset_state();
    logic [31:0] d;
    logic [1:0] r;
    chk({30'h0, irq, bus.interrupt_out_first_n}, 32'h1);
    axi_rd(8'h40, d, r);
    chk({r, d[29:0]}, 32'h80000000);
  endtask
  task automatic t_lanes32();
    logic [7:0] ct [4] = '{8'hf0, 8'h80, 8'h20, 8'h40};
    logic [31:0] wd [4] = '{32'h44332211, 32'haabbccdd, 32'h0000ee00, 32'h00990000};
    logic [31:0] ex [4] = '{32'h44332211, 32'haa332211, 32'haa33ee11, 32'haa99ee11};
    axi_wr(`UCP_CSR_WIDTH, 32'h2);
    for (int i = 0; i < 4; i++) begin
      par_op(11'h020, wd[i], ct[i]);
      rd_port(11'h020, 32'hffffffff, ex[i]);
    end
    chk(32'(seen_cnt), 32'h4);
  endtask
  task automatic t_narrow();
    logic [7:0] ex [4] = '{8'h11, 8'hee, 8'h99, 8'haa};
    axi_wr(`UCP_CSR_WIDTH, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rd_port(11'h020 + 11'(i), 32'hff, {24'h0, ex[i]});
    end
    par_op(11'h021, 32'h5c, 8'h10);
    axi_wr(`UCP_CSR_WIDTH, 32'h5);
    @(posedge aclk);
    chk({31'h0, endian_big}, 32'h1);
    axi_wr(`UCP_CSR_WIDTH, 32'h1);
    par_op(11'h022, 32'h7788, 8'h30);
    rd_port(11'h022, 32'hffff, 32'h7788);
    axi_wr(`UCP_CSR_WIDTH, 32'h2);
    rd_port(11'h020, 32'hffffffff, 32'h77885c11);
  endtask
  task automatic t_irq();
    logic [31:0] d;
    logic [1:0] r;
    int n;
    irq_enable <= 8'h01;
    irq_trigger <= 8'h01;
    @(posedge aclk);
    irq_trigger <= 8'h00;
    for (n = 0; n < 20 && bus.interrupt_out_first_n !== 1'b0; n++) @(posedge aclk);
    chk({24'h0, irq_status}, 32'h1);
    chk({31'h0, bus.interrupt_out_first_n}, 32'h0);
    axi_rd(`UCP_CSR_IRQ_STAT, d, r);
    chk({31'h0, d[1]}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    axi_wr(`UCP_CSR_MASK, 32'h2);
    @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    irq_clear <= 8'h01;
    @(posedge aclk);
    irq_clear <= 8'h00;
    repeat (2) @(posedge aclk);
    chk({31'h0, bus.interrupt_out_first_n}, 32'h1);
    axi_wr(`UCP_CSR_IRQ_STAT, 32'h3);
    axi_rd(`UCP_CSR_IRQ_STAT, d, r);
    chk(d & 32'h3, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // A trigger in the clearing cycle must survive the clear
    irq_trigger <= 8'h01;
    @(posedge aclk);
    irq_clear <= 8'h01;
    @(posedge aclk);
    irq_trigger <= 8'h00;
    irq_clear <= 8'h00;
    @(posedge aclk);
    chk({24'h0, irq_status}, 32'h1);
  endtask
  task automatic t_hw_reset();
    low_cnt = 0;
    par_op(11'h000, 32'h0, 8'h02);
    chk(32'(low_cnt), 32'(`UCP_RST_MIN_CYC + 1));
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_state();
    t_lanes32();
    t_narrow();
    t_irq();
    t_hw_reset();
    print_verdict();
  end
endmodule

// file: verilog/ucp_defs.svh
/*
  Constants of the parallel host port: register addresses, address widths,
  reset hold count and host strobe timing.
  Assumes inclusion through its bare name by the package and modules.
*/
`ifndef UCP_DEFS_SVH
`define UCP_DEFS_SVH
`define UCP_ADDR_W 11
`define UCP_UPPER_ADDR_LSB 2
`define UCP_RST_MIN_CYC 10
`define UCP_STROBE_CYC 3
`define UCP_MEM_WORDS 512
`define UCP_MEM_IDX_W 9
`define UCP_IRQ_W 8
`define UCP_CSR_CTRL 8'h00
`define UCP_CSR_ADDR 8'h04
`define UCP_CSR_WDATA 8'h08
`define UCP_CSR_RDATA 8'h0c
`define UCP_CSR_STAT 8'h10
`define UCP_CSR_MASK 8'h14
`define UCP_CSR_IRQ_STAT 8'h18
`define UCP_CSR_WIDTH 8'h1c
`endif

// file: verilog/ucp_device.sv
/*
  Device end: strobe-edge write capture per byte lane, read drive, width and
  pin-role selection, shared memory and the first interrupt output.
  Assumes pins synchronous to aclk; the bench resolves data_in from both enables.
*/
`timescale 1ns/10ps
`include "ucp_defs.svh"

module ucp_device (
  input wire logic aclk,
  input wire logic aresetn,
  ucp_if.device bus,
  input wire logic [`UCP_IRQ_W-1:0] irq_trigger,
  input wire logic [`UCP_IRQ_W-1:0] irq_enable,
  input wire logic [`UCP_IRQ_W-1:0] irq_clear,
  output logic [`UCP_IRQ_W-1:0] irq_status,
  output logic endian_big,
  output logic write_seen
);
  import ucp_pkg::*;

  typedef struct packed {
    logic [3:0] wr_q;
    logic [3:0] oe_n_q;
    logic [31:0] dout_q;
    logic [`UCP_IRQ_W-1:0] stat_q;
    logic int_n_q;
    logic endian_q;
    logic seen_q;
  } ucp_dev_state_t;

  ucp_dev_state_t s_q, s_d;
  logic [7:0] mem_q [`UCP_MEM_WORDS*4];
  ucp_width_t width;
  logic [3:0] wr_now;
  logic [3:0] wr_edge;
  logic [`UCP_ADDR_W-1:0] byte_addr;
  logic [`UCP_MEM_IDX_W-1:0] idx;
  logic rd_on;

  always_comb begin
    width = ucp_decode_width(bus.width_select_high, bus.width_select_low);
    wr_now = {~bus.write_strobe_lane3_n, ~bus.write_strobe_lane2_n,
              ~bus.write_strobe_lane1_n, ~bus.write_strobe_lane0_n} & {4{~bus.chip_select_n}};
    // Lane roles by width: pins reused as address or endian lose their strobe meaning
    unique case (width)
      UCP_W32: begin
        byte_addr = {bus.upper_address, 2'h0};
      end
      UCP_W16: begin
        byte_addr = {bus.upper_address, bus.write_strobe_lane2_n, 1'h0};
        wr_now[3:2] = 2'h0;
      end
      default: begin
        byte_addr = {bus.upper_address, bus.write_strobe_lane2_n, bus.write_strobe_lane1_n};
        wr_now[3:1] = 3'h0;
      end
    endcase
    idx = byte_addr[`UCP_ADDR_W-1:2];
    rd_on = ~bus.chip_select_n & ~bus.read_strobe_n;
    wr_edge = s_q.wr_q & ~wr_now;
  end

  // Byte storage: a lane is written when its pair of lows ends on either pin
  always_ff @(posedge aclk) begin
    if (width == UCP_W32) begin
      for (int i = 0; i < 4; i++) begin
        if (wr_edge[i]) begin
          mem_q[{idx, 2'(i)}] <= bus.data_in[8*i +: 8];
        end
      end
    end else if (width == UCP_W16) begin
      for (int i = 0; i < 2; i++) begin
        if (wr_edge[i]) begin
          mem_q[{byte_addr[`UCP_ADDR_W-1:1], 1'(i)}] <= bus.data_in[8*i +: 8];
        end
      end
    end else if (wr_edge[0]) begin
      mem_q[byte_addr] <= bus.data_in[7:0];
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.wr_q = wr_now;
    s_d.seen_q = |wr_edge;
    s_d.endian_q = (width != UCP_W32) & bus.write_strobe_lane3_n;
    s_d.oe_n_q = 4'hf;
    s_d.dout_q = 32'h0;
    if (rd_on) begin
      unique case (width)
        UCP_W32: begin
          s_d.oe_n_q = 4'h0;
          for (int i = 0; i < 4; i++) begin
            s_d.dout_q[8*i +: 8] = mem_q[{idx, 2'(i)}];
          end
        end
        UCP_W16: begin
          s_d.oe_n_q = 4'hc;
          s_d.dout_q[7:0] = mem_q[{byte_addr[`UCP_ADDR_W-1:1], 1'h0}];
          s_d.dout_q[15:8] = mem_q[{byte_addr[`UCP_ADDR_W-1:1], 1'h1}];
        end
        default: begin
          s_d.oe_n_q = 4'he;
          s_d.dout_q[7:0] = mem_q[byte_addr];
        end
      endcase
    end
    // Set wins over clear so a trigger in the clearing cycle is kept
    s_d.stat_q = (s_q.stat_q & ~irq_clear) | irq_trigger;
    s_d.int_n_q = ~|(s_d.stat_q & irq_enable);
  end

  // Hardware reset pin acts like the bus reset; the host keeps it long enough
  always_ff @(posedge aclk) begin
    if (!aresetn || !bus.hw_reset_n) begin
      s_q <= '{wr_q: 4'h0, oe_n_q: 4'hf, dout_q: 32'h0, stat_q: '0, int_n_q: 1'b1,
               endian_q: 1'b0, seen_q: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.dev_data_out = s_q.dout_q;
  assign bus.dev_data_oe_n = s_q.oe_n_q;
  assign bus.interrupt_out_first_n = s_q.int_n_q;
  assign irq_status = s_q.stat_q;
  assign endian_big = s_q.endian_q;
  assign write_seen = s_q.seen_q;
endmodule

// file: verilog/ucp_host.sv
/*
  Host end: AXI4-Lite slave with command registers, driving the parallel
  pins; reset pulse, width straps, endian level, interrupt status and mask.
  Assumes pins of the device are synchronous to aclk.
*/
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "ucp_defs.svh"
module ucp_host (
  input wire logic aclk,
  input wire logic aresetn,
  ucp_if.host bus,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  import ucp_pkg::*;

  typedef struct packed {
    ucp_hstate_t st;
    logic [3:0] cnt;
    logic [3:0] lanes;
    logic is_rd;
    logic [10:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [2:0] width;
    logic busy;
    logic [1:0] stat;
    logic [1:0] mask;
    logic int_prev;
    logic aw, w, bv, arr, rv;
    logic [7:0] awaddr;
    logic [31:0] axw;
    logic [31:0] rd_out;
    logic [1:0] rresp;
    logic irq;
  } ucp_host_state_t;

  ucp_host_state_t s_q, s_d;
  logic [1:0] ev;

  always_comb begin
    s_d = s_q;
    ev = 2'h0;
    s_d.int_prev = bus.interrupt_out_first_n;
    if (s_q.int_prev && !bus.interrupt_out_first_n) begin
      ev[1] = 1'b1;
    end
    // AXI write: address and data taken independently, answered once both are in
    if (s_axi_awvalid && !s_q.aw && !s_q.bv) begin
      s_d.aw = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w && !s_q.bv) begin
      s_d.w = 1'b1;
      s_d.axw = s_axi_wdata;
    end
    if (s_q.aw && s_q.w) begin
      s_d.aw = 1'b0;
      s_d.w = 1'b0;
      s_d.bv = 1'b1;
      unique case (s_q.awaddr)
        `UCP_CSR_CTRL: begin
          // Commands while busy are dropped; software polls the busy bit first
          if (!s_q.busy) begin
            s_d.busy = 1'b1;
            s_d.is_rd = s_q.axw[0];
            s_d.lanes = s_q.axw[7:4];
            s_d.st = s_q.axw[1] ? UCP_H_RESET : UCP_H_SETUP;
            s_d.cnt = 4'h0;
          end
        end
        `UCP_CSR_ADDR: s_d.addr = s_q.axw[10:0];
        `UCP_CSR_WDATA: s_d.wdata = s_q.axw;
        `UCP_CSR_MASK: s_d.mask = s_q.axw[1:0];
        `UCP_CSR_IRQ_STAT: s_d.stat = s_q.stat & ~s_q.axw[1:0];
        `UCP_CSR_WIDTH: s_d.width = s_q.axw[2:0];
        default: ;
      endcase
    end
    if (s_q.bv && s_axi_bready) begin
      s_d.bv = 1'b0;
    end
    s_d.arr = 1'b0;
    if (s_axi_arvalid && !s_q.arr && !s_q.rv) begin
      s_d.arr = 1'b1;
      s_d.rv = 1'b1;
      s_d.rresp = 2'h0;
      unique case (s_axi_araddr)
        `UCP_CSR_CTRL: s_d.rd_out = {24'h0, s_q.lanes, 2'h0, 1'b0, s_q.is_rd};
        `UCP_CSR_ADDR: s_d.rd_out = {21'h0, s_q.addr};
        `UCP_CSR_WDATA: s_d.rd_out = s_q.wdata;
        `UCP_CSR_RDATA: s_d.rd_out = s_q.rdata;
        `UCP_CSR_STAT: s_d.rd_out = {30'h0, ~bus.interrupt_out_first_n, s_q.busy};
        `UCP_CSR_MASK: s_d.rd_out = {30'h0, s_q.mask};
        `UCP_CSR_IRQ_STAT: s_d.rd_out = {30'h0, s_q.stat};
        `UCP_CSR_WIDTH: s_d.rd_out = {29'h0, s_q.width};
        default: begin
          s_d.rd_out = 32'h0;
          s_d.rresp = 2'h2;
        end
      endcase
    end
    if (s_q.rv && s_axi_rready) begin
      s_d.rv = 1'b0;
    end
    // Parallel cycle: setup, strobe held, release with select so capture edges land
    unique case (s_q.st)
      UCP_H_IDLE: ;
      UCP_H_SETUP: s_d.st = UCP_H_STROBE;
      UCP_H_STROBE: begin
        s_d.cnt = s_q.cnt + 4'h1;
        if (s_q.cnt == 4'(`UCP_STROBE_CYC - 1)) begin
          s_d.st = UCP_H_HOLD;
          if (s_q.is_rd) begin
            s_d.rdata = bus.data_in;
          end
        end
      end
      UCP_H_HOLD: begin
        s_d.st = UCP_H_IDLE;
        s_d.busy = 1'b0;
        ev[0] = 1'b1;
      end
      UCP_H_RESET: begin
        s_d.cnt = s_q.cnt + 4'h1;
        if (s_q.cnt == 4'(`UCP_RST_MIN_CYC)) begin
          s_d.st = UCP_H_IDLE;
          s_d.busy = 1'b0;
          ev[0] = 1'b1;
        end
      end
      default: s_d.st = UCP_H_IDLE;
    endcase
    s_d.stat = s_d.stat | ev;
    s_d.irq = |(s_d.stat & s_q.mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.st <= UCP_H_IDLE;
      s_q.int_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  logic cs_on, strobe_on, narrow;
  assign cs_on = s_q.st inside {UCP_H_SETUP, UCP_H_STROBE};
  assign strobe_on = s_q.st == UCP_H_STROBE;
  assign narrow = !s_q.width[1];
  assign bus.width_select_high = s_q.width[1];
  assign bus.width_select_low = s_q.width[0];
  assign bus.hw_reset_n = s_q.st != UCP_H_RESET;
  assign bus.chip_select_n = !cs_on;
  assign bus.read_strobe_n = !(strobe_on && s_q.is_rd);
  assign bus.upper_address = s_q.addr[10:2];
  assign bus.write_strobe_lane0_n = !(strobe_on && !s_q.is_rd && s_q.lanes[0]);
  assign bus.write_strobe_lane1_n = (narrow && !s_q.width[0]) ? s_q.addr[0]
                                   : !(strobe_on && !s_q.is_rd && s_q.lanes[1]);
  assign bus.write_strobe_lane2_n = narrow ? s_q.addr[1] : !(strobe_on && !s_q.is_rd && s_q.lanes[2]);
  assign bus.write_strobe_lane3_n = narrow ? s_q.width[2]
                                   : !(strobe_on && !s_q.is_rd && s_q.lanes[3]);
  assign bus.host_data_out = s_q.wdata;
  // Write data stays through the hold cycle: the device captures on the strobe rise seen there
  assign bus.host_data_oe_n = {4{!((cs_on || s_q.st == UCP_H_HOLD) && !s_q.is_rd)}};
  assign s_axi_awready = s_q.aw;
  assign s_axi_wready = s_q.w;
  assign s_axi_bvalid = s_q.bv;
  assign s_axi_bresp = 2'h0;
  assign s_axi_arready = s_q.arr;
  assign s_axi_rvalid = s_q.rv;
  assign s_axi_rdata = s_q.rd_out;
  assign s_axi_rresp = s_q.rresp;
  assign irq = s_q.irq;
endmodule

// file: verilog/ucp_if.sv
/*
  Pin-level carrier between the host end and the device end.
  Assumes the bench resolves the shared data wire from the enables.
*/
`timescale 1ns/10ps
interface ucp_if;
  logic width_select_low;
  logic width_select_high;
  logic chip_select_n;
  logic read_strobe_n;
  logic write_strobe_lane0_n;
  logic write_strobe_lane1_n;
  logic write_strobe_lane2_n;
  logic write_strobe_lane3_n;
  logic [10:2] upper_address;
  logic hw_reset_n;
  logic interrupt_out_first_n;
  logic [31:0] host_data_out;
  logic [3:0] host_data_oe_n;
  logic [31:0] dev_data_out;
  logic [3:0] dev_data_oe_n;
  logic [31:0] data_in;

  modport device (
    input width_select_low, width_select_high, chip_select_n, read_strobe_n,
    input write_strobe_lane0_n, write_strobe_lane1_n, write_strobe_lane2_n, write_strobe_lane3_n,
    input upper_address, hw_reset_n, data_in,
    output interrupt_out_first_n, dev_data_out, dev_data_oe_n
  );
  modport host (
    output width_select_low, width_select_high, chip_select_n, read_strobe_n,
    output write_strobe_lane0_n, write_strobe_lane1_n, write_strobe_lane2_n, write_strobe_lane3_n,
    output upper_address, hw_reset_n, host_data_out, host_data_oe_n,
    input interrupt_out_first_n, data_in
  );
endinterface

// file: verilog/ucp_pkg.sv
/*
  Types shared by both ends of the parallel host port.
  Assumes ucp_defs.svh is on the include path.
*/
`include "ucp_defs.svh"
package ucp_pkg;
  typedef enum logic [1:0] {
    UCP_W8 = 2'h0,
    UCP_W16 = 2'h1,
    UCP_W32 = 2'h2
  } ucp_width_t;

  typedef enum logic [4:0] {
    UCP_H_IDLE = 5'h01,
    UCP_H_SETUP = 5'h02,
    UCP_H_STROBE = 5'h04,
    UCP_H_HOLD = 5'h08,
    UCP_H_RESET = 5'h10
  } ucp_hstate_t;

  function automatic ucp_width_t ucp_decode_width(input logic hi, input logic lo);
    if (hi) begin
      return UCP_W32;
    end else if (lo) begin
      return UCP_W16;
    end
    return UCP_W8;
  endfunction
endpackage
